/* File: rtl/spi_crc_pkg.sv */
// Constants and types for the CRC-protected SPI command port
package spi_crc_pkg;
	localparam int ADDR_W = 12;
	localparam int BYTE_W = 8;
	localparam int WORD_W = 32;
	localparam int CRC_W = 16;
	localparam int CNT_W = 10;
	localparam logic [3:0] CMD_WRITE = 4'h2;
	localparam logic [3:0] CMD_RD_CRC = 4'hb;
	localparam logic [3:0] CMD_WR_CRC = 4'ha;
	localparam logic [3:0] CMD_WR_SAFE = 4'hc;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'h8005;
	localparam logic [11:0] REG_END = 12'h3ff;
	localparam logic [11:0] REG_BASE = 12'h000;
	localparam logic [11:0] RAM_LO = 12'h400;
	localparam logic [11:0] RAM_HI = 12'hbff;
	localparam logic [11:0] TOP_HI = 12'hfff;
	localparam logic [11:0] TOP_LO = 12'he00;
	localparam logic [11:0] WORD_LAST = 12'h003;
	localparam logic [1:0] LANE_LAST = 2'h3;
	localparam logic [2:0] CMD_DONE_BIT = 3'h3;
	localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
	localparam logic [9:0] SAFE_REG_BYTES = 10'h001;
	localparam logic [9:0] SAFE_RAM_BYTES = 10'h004;
	typedef enum logic [2:0] {PH_HDR, PH_CNT, PH_DATA, PH_CRC, PH_DONE, PH_IDLE} phase_t;
endpackage : spi_crc_pkg

/* File: rtl/spi_crc_command_port.sv */
// SPI command port with CRC checking, message-memory word writes and status flags
`timescale 1ns/1ps
module spi_crc_command_port (
	// System clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// SPI link
	input wire logic sck,
	input wire logic select_low,
	input wire logic sdi,
	output logic sdo,
	output logic sdo_oe,
	// Register space write
	output logic reg_wr_en,
	output logic [spi_crc_pkg::ADDR_W-1:0] reg_wr_addr,
	output logic [spi_crc_pkg::BYTE_W-1:0] reg_wr_data,
	// Register space read
	output logic reg_rd_en,
	input wire logic [spi_crc_pkg::BYTE_W-1:0] reg_rd_data,
	// Message memory write
	output logic ram_wr_en,
	output logic [spi_crc_pkg::ADDR_W-1:0] ram_wr_addr,
	output logic [spi_crc_pkg::WORD_W-1:0] ram_wr_data,
	// Message memory read
	output logic ram_rd_en,
	input wire logic [spi_crc_pkg::WORD_W-1:0] ram_rd_data,
	// Shared read address
	output logic [spi_crc_pkg::ADDR_W-1:0] rd_addr,
	// CRC status
	input wire logic clr_mismatch,
	input wire logic clr_frame_error,
	output logic crc_mismatch_flag,
	output logic crc_frame_error_flag,
	output logic [spi_crc_pkg::CRC_W-1:0] crc_value
);
	import spi_crc_pkg::*;

	typedef struct packed {
		logic frm_t;
		phase_t ph;
		logic hb;
		logic [2:0] bits;
		logic [7:0] shin;
		logic [3:0] cmd;
		logic [11:0] addr;
		logic ram;
		logic [9:0] dleft;
		logic [15:0] crc;
		logic [15:0] rxcrc;
		logic crcb;
		logic [7:0] wbyte;
		logic [31:0] wbuf;
		logic [11:0] waddr;
		logic wram;
		logic commit;
		logic bnd;
		logic rd_t;
		logic [11:0] rptr;
		logic [11:0] rd_addr;
	} link_t;

	typedef struct packed {
		logic [7:0] out;
		logic wr_t;
	} tx_t;

	typedef struct packed {
		logic cs1;
		logic cs2;
		logic cs3;
		logic wr1;
		logic wr2;
		logic wr3;
		logic rd1;
		logic rd2;
		logic rd3;
		logic frm1;
		logic frm2;
		logic frm_seen;
		logic rd_pend;
		logic [31:0] hold;
		logic reg_wr_en;
		logic [11:0] reg_wr_addr;
		logic [7:0] reg_wr_data;
		logic ram_wr_en;
		logic [11:0] ram_wr_addr;
		logic [31:0] ram_wr_data;
		logic reg_rd_en;
		logic ram_rd_en;
		logic [11:0] rd_addr;
		logic mm;
		logic fe;
		logic [15:0] crc_val;
	} sys_t;

	logic rs1_q;
	logic rst_s;
	logic frame_q;
	link_t lk_q;
	link_t lk_d;
	tx_t tx_q;
	tx_t tx_d;
	sys_t sy_q;
	sys_t sy_d;

	function automatic logic [11:0] adv(input logic [11:0] a);
		if (a == REG_END) begin
			adv = REG_BASE;
		end else if (a == RAM_HI) begin
			adv = RAM_LO;
		end else if (a == TOP_HI) begin
			adv = TOP_LO;
		end else begin
			adv = a + 12'h001;
		end
	endfunction : adv

	// Reset release through two flip-flops
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rs1_q <= 1'b0;
			rst_s <= 1'b0;
		end else begin
			rs1_q <= 1'b1;
			rst_s <= rs1_q;
		end
	end

	// Frame marker: cleared as soon as the select pin goes idle
	always_ff @(posedge sck or posedge select_low or negedge rst_s) begin
		if (!rst_s) begin
			frame_q <= 1'b0;
		end else if (select_low) begin
			frame_q <= 1'b0;
		end else begin
			frame_q <= 1'b1;
		end
	end

	// Link logic on the rising SCK edge
	always_comb begin
		logic [7:0] b;
		logic [2:0] bi;
		logic fb;
		logic fetch;
		logic [11:0] a;
		logic [11:0] na;
		b = {lk_q.shin[6:0], sdi};
		bi = 3'h0;
		fb = 1'b0;
		fetch = 1'b0;
		a = 12'h000;
		na = 12'h000;
		lk_d = lk_q;
		lk_d.commit = 1'b0;
		lk_d.bnd = 1'b0;
		if (!frame_q) begin
			lk_d.frm_t = ~lk_q.frm_t;
			lk_d.ph = PH_HDR;
			lk_d.hb = 1'b0;
			lk_d.bits = 3'h0;
			lk_d.crc = CRC_INIT;
			lk_d.crcb = 1'b0;
		end
		bi = lk_d.bits;
		fb = lk_d.crc[15] ^ ((lk_d.ph == PH_DATA && lk_d.cmd == CMD_RD_CRC) ? tx_q.out[7] : sdi);
		if (lk_d.ph == PH_HDR || lk_d.ph == PH_CNT || lk_d.ph == PH_DATA) begin
			lk_d.crc = {lk_d.crc[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
		end
		lk_d.shin = b;
		lk_d.bits = bi + 3'h1;
		if (lk_d.ph == PH_HDR && !lk_d.hb && bi == CMD_DONE_BIT) begin
			lk_d.cmd = b[3:0];
		end
		if (bi == BYTE_LAST_BIT) begin
			lk_d.bnd = 1'b1;
			case (lk_d.ph)
				PH_HDR: begin
					if (!lk_d.hb) begin
						lk_d.addr[11:8] = b[3:0];
						lk_d.hb = 1'b1;
					end else begin
						a = {lk_d.addr[11:8], b};
						lk_d.ram = (a >= RAM_LO) && (a <= RAM_HI);
						if (lk_d.ram) begin
							a[1:0] = 2'h0;
						end
						lk_d.addr = a;
						lk_d.rptr = a;
						case (lk_d.cmd)
							CMD_RD_CRC: begin
								lk_d.ph = PH_CNT;
								fetch = 1'b1;
							end
							CMD_WR_CRC: begin
								lk_d.ph = PH_CNT;
							end
							CMD_WR_SAFE: begin
								lk_d.ph = PH_DATA;
								lk_d.dleft = lk_d.ram ? SAFE_RAM_BYTES : SAFE_REG_BYTES;
							end
							CMD_WRITE: begin
								lk_d.ph = PH_DATA;
							end
							default: begin
								lk_d.ph = PH_IDLE;
							end
						endcase
					end
				end
				PH_CNT: begin
					lk_d.dleft = lk_d.ram ? {b, 2'b00} : {2'b00, b};
					lk_d.ph = (b == 8'h00) ? PH_CRC : PH_DATA;
					fetch = (lk_d.cmd == CMD_RD_CRC) && !lk_d.ram;
				end
				PH_DATA: begin
					na = adv(lk_d.addr);
					if (lk_d.cmd == CMD_RD_CRC) begin
						fetch = !lk_d.ram || (na[1:0] == LANE_LAST);
					end else begin
						lk_d.wbyte = b;
						lk_d.waddr = lk_d.addr;
						lk_d.wram = lk_d.ram;
						lk_d.wbuf[8*lk_d.addr[1:0] +: 8] = b;
						if (lk_d.cmd != CMD_WR_SAFE) begin
							lk_d.commit = !lk_d.ram || (lk_d.addr[1:0] == LANE_LAST);
						end
					end
					lk_d.addr = na;
					lk_d.dleft = lk_d.dleft - 10'h001;
					if (lk_d.cmd != CMD_WRITE && lk_d.dleft == 10'h000) begin
						lk_d.ph = PH_CRC;
					end
				end
				PH_CRC: begin
					lk_d.rxcrc = {lk_d.rxcrc[7:0], b};
					lk_d.crcb = 1'b1;
					if (lk_d.crcb && lk_q.crcb) begin
						lk_d.ph = PH_DONE;
					end
				end
				default: begin
					lk_d.ph = lk_d.ph;
				end
			endcase
		end
		if (fetch) begin
			lk_d.rd_t = ~lk_d.rd_t;
			lk_d.rd_addr = lk_d.rptr;
			lk_d.rptr = lk_d.ram ? adv(lk_d.rptr | WORD_LAST) : adv(lk_d.rptr);
		end
	end

	always_ff @(posedge sck or negedge rst_s) begin
		if (!rst_s) begin
			lk_q <= '0;
		end else begin
			lk_q <= lk_d;
		end
	end

	// Output shifter and commit events on the falling SCK edge
	always_comb begin
		tx_d = tx_q;
		tx_d.out = {tx_q.out[6:0], 1'b0};
		if (frame_q && lk_q.commit) begin
			tx_d.wr_t = ~tx_q.wr_t;
		end
		if (frame_q && lk_q.bnd) begin
			if (lk_q.ph == PH_DATA && lk_q.cmd == CMD_RD_CRC) begin
				tx_d.out = lk_q.ram ? sy_q.hold[8*lk_q.addr[1:0] +: 8] : sy_q.hold[7:0];
			end else if (lk_q.ph == PH_CRC && lk_q.cmd == CMD_RD_CRC) begin
				tx_d.out = lk_q.crcb ? lk_q.crc[7:0] : lk_q.crc[15:8];
			end
		end
	end

	always_ff @(negedge sck or negedge rst_s) begin
		if (!rst_s) begin
			tx_q <= '0;
		end else begin
			tx_q <= tx_d;
		end
	end

	assign sdo = tx_q.out[7];
	assign sdo_oe = ~select_low;

	// System side: crossings, memory strobes, frame-end checks
	always_comb begin
		logic chk;
		chk = 1'b0;
		sy_d = sy_q;
		sy_d.cs1 = select_low;
		sy_d.cs2 = sy_q.cs1;
		sy_d.cs3 = sy_q.cs2;
		sy_d.wr1 = tx_q.wr_t;
		sy_d.wr2 = sy_q.wr1;
		sy_d.wr3 = sy_q.wr2;
		sy_d.rd1 = lk_q.rd_t;
		sy_d.rd2 = sy_q.rd1;
		sy_d.rd3 = sy_q.rd2;
		sy_d.frm1 = lk_q.frm_t;
		sy_d.frm2 = sy_q.frm1;
		sy_d.reg_wr_en = 1'b0;
		sy_d.ram_wr_en = 1'b0;
		sy_d.reg_rd_en = 1'b0;
		sy_d.ram_rd_en = 1'b0;
		sy_d.rd_pend = 1'b0;
		sy_d.mm = sy_q.mm & ~clr_mismatch;
		sy_d.fe = sy_q.fe & ~clr_frame_error;
		if (sy_q.wr2 != sy_q.wr3) begin
			if (lk_q.wram) begin
				sy_d.ram_wr_en = 1'b1;
				sy_d.ram_wr_addr = {lk_q.waddr[11:2], 2'b00};
				sy_d.ram_wr_data = lk_q.wbuf;
			end else begin
				sy_d.reg_wr_en = 1'b1;
				sy_d.reg_wr_addr = lk_q.waddr;
				sy_d.reg_wr_data = lk_q.wbyte;
			end
		end
		if (sy_q.rd2 != sy_q.rd3) begin
			sy_d.ram_rd_en = lk_q.ram;
			sy_d.reg_rd_en = ~lk_q.ram;
			sy_d.rd_addr = lk_q.rd_addr;
			sy_d.rd_pend = 1'b1;
		end
		if (sy_q.rd_pend) begin
			sy_d.hold = lk_q.ram ? ram_rd_data : {24'h000000, reg_rd_data};
		end
		if (sy_q.cs2 && !sy_q.cs3 && sy_q.frm2 != sy_q.frm_seen) begin
			sy_d.frm_seen = sy_q.frm2;
			chk = lk_q.cmd == CMD_RD_CRC || lk_q.cmd == CMD_WR_CRC || lk_q.cmd == CMD_WR_SAFE;
			if (chk && lk_q.ph != PH_DONE) begin
				sy_d.fe = 1'b1;
			end else if (chk && lk_q.cmd != CMD_RD_CRC) begin
				if (lk_q.rxcrc != lk_q.crc) begin
					sy_d.mm = 1'b1;
					sy_d.crc_val = lk_q.crc;
				end else if (lk_q.cmd == CMD_WR_SAFE) begin
					if (lk_q.wram) begin
						sy_d.ram_wr_en = 1'b1;
						sy_d.ram_wr_addr = {lk_q.waddr[11:2], 2'b00};
						sy_d.ram_wr_data = lk_q.wbuf;
					end else begin
						sy_d.reg_wr_en = 1'b1;
						sy_d.reg_wr_addr = lk_q.waddr;
						sy_d.reg_wr_data = lk_q.wbyte;
					end
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_s) begin
		if (!rst_s) begin
			sy_q <= '0;
			sy_q.cs1 <= 1'b1;
			sy_q.cs2 <= 1'b1;
			sy_q.cs3 <= 1'b1;
		end else begin
			sy_q <= sy_d;
		end
	end

	assign reg_wr_en = sy_q.reg_wr_en;
	assign reg_wr_addr = sy_q.reg_wr_addr;
	assign reg_wr_data = sy_q.reg_wr_data;
	assign ram_wr_en = sy_q.ram_wr_en;
	assign ram_wr_addr = sy_q.ram_wr_addr;
	assign ram_wr_data = sy_q.ram_wr_data;
	assign reg_rd_en = sy_q.reg_rd_en;
	assign ram_rd_en = sy_q.ram_rd_en;
	assign rd_addr = sy_q.rd_addr;
	assign crc_mismatch_flag = sy_q.mm;
	assign crc_frame_error_flag = sy_q.fe;
	assign crc_value = sy_q.crc_val;
endmodule : spi_crc_command_port

/* File: sim/spi_crc_command_port_properties.sv */
// Concurrent checks on the command port pins
`timescale 1ns/1ps
module spi_crc_command_port_properties (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Link and strobes
	input wire logic select_low,
	input wire logic sdo_oe,
	input wire logic reg_wr_en,
	input wire logic ram_wr_en,
	input wire logic [spi_crc_pkg::ADDR_W-1:0] ram_wr_addr,
	input wire logic ram_rd_en,
	input wire logic [spi_crc_pkg::ADDR_W-1:0] rd_addr,
	// Status
	input wire logic clr_mismatch,
	input wire logic clr_frame_error,
	input wire logic crc_mismatch_flag,
	input wire logic crc_frame_error_flag,
	input wire logic [spi_crc_pkg::CRC_W-1:0] crc_value
);
	import spi_crc_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	property p_oe; sdo_oe == !select_low; endproperty
	a_oe: assert property (p_oe) else $error("sdo_oe wrong");
	property p_wr1; ram_wr_en |=> !ram_wr_en; endproperty
	a_wr1: assert property (p_wr1) else $error("ram write too long");
	property p_wal; ram_wr_en |-> ram_wr_addr[1:0] == 2'h0; endproperty
	a_wal: assert property (p_wal) else $error("ram write unaligned");
	property p_ral; ram_rd_en |-> rd_addr[1:0] == 2'h0 ##1 !ram_rd_en; endproperty
	a_ral: assert property (p_ral) else $error("ram read unaligned");
	property p_reg; reg_wr_en |=> !reg_wr_en; endproperty
	a_reg: assert property (p_reg) else $error("reg write too long");
	property p_mis; $rose(crc_mismatch_flag) |-> select_low [*2]; endproperty
	a_mis: assert property (p_mis) else $error("mismatch inside frame");
	property p_fer; $rose(crc_frame_error_flag) |-> select_low; endproperty
	a_fer: assert property (p_fer) else $error("frame error inside frame");
	property p_mcl; $fell(crc_mismatch_flag) |-> $past(clr_mismatch); endproperty
	a_mcl: assert property (p_mcl) else $error("mismatch lost");
	property p_fcl; $fell(crc_frame_error_flag) |-> $past(clr_frame_error); endproperty
	a_fcl: assert property (p_fcl) else $error("frame error lost");
	property p_val; $changed(crc_value) |-> crc_mismatch_flag; endproperty
	a_val: assert property (p_val) else $error("crc value without flag");
endmodule : spi_crc_command_port_properties
bind spi_crc_command_port spi_crc_command_port_properties chk_inst (.sys_clk, .rstn,
	.select_low, .sdo_oe, .reg_wr_en, .ram_wr_en, .ram_wr_addr, .ram_rd_en, .rd_addr,
	.clr_mismatch, .clr_frame_error, .crc_mismatch_flag, .crc_frame_error_flag, .crc_value);

/* File: sim/spi_host_model.sv */
// Host master model shifting frames on the link
`timescale 1ns/1ps
module spi_host_model (
	// Link
	output logic sck,
	output logic select_low,
	output logic sdi,
	input wire logic sdo
);
	localparam int HP = 120;
	initial begin
		sck = 1'b0;
		select_low = 1'b1;
		sdi = 1'b0;
	end
	task automatic run(input logic [0:127] tx, input int n, output logic [0:127] rx);
		rx = '0;
		#7;
		select_low = 1'b0;
		for (int i = 0; i < n; i++) begin
			sdi = tx[i];
			#HP;
			sck = 1'b1;
			rx[i] = sdo;
			#HP;
			sck = 1'b0;
		end
		#HP;
		select_low = 1'b1;
		sdi = ~sdi;
		#600;
	endtask : run
endmodule : spi_host_model

/* File: sim/spi_crc_command_port_tb.sv */
// Self-checking bench of the command port
`timescale 1ns/1ps
module spi_crc_command_port_tb;
	import spi_crc_pkg::*;
	logic sys_clk = 1'b0, rstn = 1'b0, sck, select_low, sdi, sdo, sdo_oe;
	logic reg_wr_en, reg_rd_en, ram_wr_en, ram_rd_en, mis, fer;
	logic clr_mismatch = 1'b0, clr_frame_error = 1'b0;
	logic [11:0] reg_wr_addr, ram_wr_addr, rd_addr, reg_a, ram_a;
	logic [7:0] reg_wr_data, reg_d, reg_rd_data = 8'h00;
	logic [31:0] ram_wr_data, ram_d, ram_rd_data = 32'h0;
	logic [15:0] crc_value;
	logic [0:127] tx, rx;
	int n, err_total, n_tests, n_reg, n_ram;
	always #50 sys_clk = ~sys_clk;
	spi_crc_command_port spi_crc_command_port_inst (.sys_clk, .rstn, .sck, .select_low,
		.sdi, .sdo, .sdo_oe, .reg_wr_en, .reg_wr_addr, .reg_wr_data, .reg_rd_en,
		.reg_rd_data, .ram_wr_en, .ram_wr_addr, .ram_wr_data, .ram_rd_en, .ram_rd_data,
		.rd_addr, .clr_mismatch, .clr_frame_error, .crc_mismatch_flag(mis),
		.crc_frame_error_flag(fer), .crc_value);
	spi_host_model spi_host_model_inst (.sck, .select_low, .sdi, .sdo);
	// Read data answers within the strobe cycle
	always @(negedge sys_clk) begin
		if (reg_rd_en === 1'b1) reg_rd_data <= rd_addr[7:0] ^ 8'h5a;
		if (ram_rd_en === 1'b1) ram_rd_data <= {rd_addr[7:0] + 8'h13,
			rd_addr[7:0] + 8'h12, rd_addr[7:0] + 8'h11, rd_addr[7:0] + 8'h10};
	end
	always @(posedge sys_clk) begin
		if (reg_wr_en === 1'b1) begin
			n_reg++;
			reg_a = reg_wr_addr;
			reg_d = reg_wr_data;
		end
		if (ram_wr_en === 1'b1) begin
			n_ram++;
			ram_a = ram_wr_addr;
			ram_d = ram_wr_data;
		end
	end
	task end_sim;
		$display("tests %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_sim
	task chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task put(input logic [31:0] v, input int w);
		for (int i = w - 1; i >= 0; i--) begin
			tx[n] = v[i];
			n++;
		end
	endtask : put
	function automatic logic [15:0] crc(input int len);
		logic [15:0] c = 16'hffff;
		for (int i = 0; i < len; i++) c = {c[14:0], 1'b0} ^ ((c[15] ^ tx[i]) ? 16'h8005 : 16'h0);
		return c;
	endfunction : crc
	task go(input logic [3:0] cmd, input logic [11:0] a);
		n = 0;
		tx = '0;
		put(cmd, 4);
		put(a, 12);
	endtask : go
	task fin(input logic bad);
		put(crc(n) ^ {15'h0, bad}, 16);
		spi_host_model_inst.run(tx, n, rx);
	endtask : fin
	task clr;
		@(posedge sys_clk) #2 {clr_mismatch, clr_frame_error} = 2'h3;
		@(posedge sys_clk) #2 {clr_mismatch, clr_frame_error} = 2'h0;
		@(posedge sys_clk) #2 chk("flags clear", {mis, fer}, 2'h0);
	endtask : clr
	task automatic t_plain;
		int b = n_ram;
		go(CMD_WRITE, 12'h402);
		put(32'h11223344, 32);
		put(8'h55, 8);
		spi_host_model_inst.run(tx, n, rx);
		chk("ram writes", n_ram - b, 1);
		chk("ram addr", ram_a, 12'h400);
		chk("ram data", ram_d, 32'h44332211);
	endtask : t_plain
	task automatic t_cwr(input logic bad);
		int b = n_reg;
		go(CMD_WR_CRC, 12'h3ff);
		put(2, 8);
		put(16'h55aa, 16);
		fin(bad);
		chk("reg writes", n_reg - b, 2);
		chk("reg addr", reg_a, 12'h000);
		chk("reg data", reg_d, 8'haa);
		chk("mismatch", mis, bad);
		if (bad) chk("crc value", crc_value, crc(n - 16));
		clr;
	endtask : t_cwr
	task automatic t_safe(input logic bad);
		int b = n_reg;
		go(CMD_WR_SAFE, 12'h020);
		put(8'h3c, 8);
		fin(bad);
		chk("safe writes", n_reg - b, !bad);
		chk("safe mismatch", mis, bad);
		if (!bad) chk("safe data", {reg_a, reg_d}, 20'h0203c);
		clr;
	endtask : t_safe
	task t_read(input logic [11:0] a, input int w, input logic [31:0] d);
		go(CMD_RD_CRC, a);
		put(1, 8);
		put(d, w);
		fin(1'b0);
		chk("read back", rx[24+:48], tx[24+:48]);
		chk("read flags", {mis, fer}, 2'h0);
	endtask : t_read
	task automatic t_ram(input logic [3:0] cmd);
		int b = n_ram;
		go(cmd, 12'h7fe);
		if (cmd == CMD_WR_CRC) put(1, 8);
		put(32'ha1b2c3d4, 32);
		fin(1'b0);
		chk("ram crc writes", n_ram - b, 1);
		chk("ram crc word", {ram_a, ram_d}, {12'h7fc, 32'hd4c3b2a1});
		chk("ram crc flags", {mis, fer}, 2'h0);
	endtask : t_ram
	task t_early(input logic [3:0] cmd, input int len);
		go(cmd, 12'h010);
		put(1, 8);
		put(16'h01ff, 16);
		spi_host_model_inst.run(tx, len, rx);
		chk("frame error", {mis, fer}, 2'h1);
		clr;
	endtask : t_early
	initial begin
		repeat (16) @(posedge sys_clk);
		#2 rstn = 1'b1;
		repeat (4) @(posedge sys_clk);
		t_plain;
		t_cwr(1'b0);
		t_cwr(1'b1);
		t_safe(1'b1);
		t_safe(1'b0);
		t_read(12'h020, 8, 32'h7a);
		t_read(12'h401, 32, 32'h10111213);
		t_ram(CMD_WR_CRC);
		t_ram(CMD_WR_SAFE);
		t_early(CMD_WR_CRC, 40);
		t_early(CMD_RD_CRC, 40);
		end_sim;
	end
	initial begin
		#2000000;
		err_total++;
		end_sim;
	end
endmodule : spi_crc_command_port_tb
